// >>> shared/cab_regs.svh
// timing counts, field positions and constants for the execute block
`ifndef CAB_REGS_SVH
`define CAB_REGS_SVH
`define CAB_CYC_ONE      2'd1
`define CAB_CYC_WORD     2'd2
`define CAB_CYC_CALL     2'd3
`define CAB_FLG_C        0
`define CAB_FLG_Z        1
`define CAB_FLG_N        2
`define CAB_FLG_V        3
`define CAB_FLG_S        4
`define CAB_FLG_H        5
`define CAB_MASK_ALL     8'h00FF
`define CAB_SP_RESET     16'h00FF
`define CAB_Z_LO         5'd30
`define CAB_Z_HI         5'd31
`endif

// >>> shared/cab_pkg.sv
// operation codes and state types for the execute block
package cab_pkg;
    typedef enum logic [4:0] {
        CAB_OP_NOP, CAB_OP_ADD, CAB_OP_ADC, CAB_OP_WADD, CAB_OP_SUB, CAB_OP_SUBK,
        CAB_OP_SUBB, CAB_OP_SUBBK, CAB_OP_WSUB, CAB_OP_AND, CAB_OP_ANDK, CAB_OP_OR,
        CAB_OP_ORK, CAB_OP_XOR, CAB_OP_TEST, CAB_OP_SETM, CAB_OP_CLRM, CAB_OP_JMPZ,
        CAB_OP_CALLZ, CAB_OP_CMPSK, CAB_OP_CMP, CAB_OP_CMPB, CAB_OP_CMPK, CAB_OP_SKRC,
        CAB_OP_SKRS, CAB_OP_SKIC, CAB_OP_SKIS
    } cab_op_e;
    typedef enum logic [2:0] {
        CAB_ALU_ADD, CAB_ALU_SUB, CAB_ALU_AND, CAB_ALU_OR, CAB_ALU_XOR
    } cab_alu_e;
    typedef enum {CAB_ST_IDLE, CAB_ST_WAIT} cab_state_e;
endpackage

// >>> hw/cab_alu.sv
// 8-bit alu with status flag generation
`timescale 1ns/10ps
`default_nettype none
`include "cab_regs.svh"
module cab_alu (
    // operands
    input  wire logic              [7:0] i_a,
    input  wire logic              [7:0] i_b,
    input  wire logic                    i_cin,
    input  wire cab_pkg::cab_alu_e       i_fn,
    // result
    output logic                   [7:0] o_res,
    output logic                   [5:0] o_flags
);
    import cab_pkg::*;
    logic [8:0] wide;
    logic       half;
    logic       ovf;
    always_comb begin
        wide = 9'h000;
        half = 1'b0;
        ovf  = 1'b0;
        case (i_fn)
            CAB_ALU_ADD: begin
                wide = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
                half = ({1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin}) > 5'h0F;
                ovf  = (i_a[7] == i_b[7]) && (wide[7] != i_a[7]);
            end
            CAB_ALU_SUB: begin
                wide = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
                half = {1'b0, i_a[3:0]} < ({1'b0, i_b[3:0]} + {4'h0, i_cin});
                ovf  = (i_a[7] != i_b[7]) && (wide[7] != i_a[7]);
            end
            CAB_ALU_AND: wide = {1'b0, i_a & i_b};
            CAB_ALU_OR:  wide = {1'b0, i_a | i_b};
            CAB_ALU_XOR: wide = {1'b0, i_a ^ i_b};
            default:     wide = 9'h000;
        endcase
        o_res = wide[7:0];
        o_flags = 6'h00;
        o_flags[`CAB_FLG_C] = wide[8];
        o_flags[`CAB_FLG_Z] = (wide[7:0] == 8'h00);
        o_flags[`CAB_FLG_N] = wide[7];
        o_flags[`CAB_FLG_V] = ovf;
        o_flags[`CAB_FLG_S] = wide[7] ^ ovf;
        o_flags[`CAB_FLG_H] = half;
    end
endmodule // cab_alu
`default_nettype wire

// >>> hw/cab_regfile.sv
// 32 x 8 working register file with one write and three read ports
`timescale 1ns/10ps
`default_nettype none
module cab_regfile (
    // clocking
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    // write port
    input  wire logic       i_we,
    input  wire logic [4:0] i_wa,
    input  wire logic [7:0] i_wd,
    // read ports
    input  wire logic [4:0] i_ra,
    input  wire logic [4:0] i_rb,
    input  wire logic [4:0] i_rc,
    output logic      [7:0] o_ra,
    output logic      [7:0] o_rb,
    output logic      [7:0] o_rc
);
    logic [7:0] regs [32];
    generate
        for (genvar g = 0; g < 32; g++) begin : g_reg
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    regs[g] <= 8'h00;
                end else if (i_ce && i_we && i_wa == 5'(g)) begin
                    regs[g] <= i_wd;
                end
            end
        end
    endgenerate
    assign o_ra = regs[i_ra];
    assign o_rb = regs[i_rb];
    assign o_rc = regs[i_rc];
endmodule // cab_regfile
`default_nettype wire

// >>> hw/cab_exec.sv
// execute stage for arithmetic, logic, jump, call, compare and skip operations
`timescale 1ns/10ps
`default_nettype none
`include "cab_regs.svh"
module cab_exec (
    // clocking
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_ce,
    // issue
    input  wire logic              i_valid,
    input  wire cab_pkg::cab_op_e  i_op,
    input  wire logic       [4:0]  i_rd,
    input  wire logic       [4:0]  i_rr,
    input  wire logic       [7:0]  i_imm,
    input  wire logic       [2:0]  i_bit,
    input  wire logic       [7:0]  i_io_val,
    input  wire logic              i_next_two_word,
    // status
    output logic                   o_ready,
    output logic                   o_done,
    output logic            [15:0] o_pc,
    output logic             [5:0] o_sreg,
    output logic            [15:0] o_sp,
    output logic                   o_push_we,
    output logic            [15:0] o_push_addr,
    output logic             [7:0] o_push_data
);
    import cab_pkg::*;

    cab_state_e state;
    logic [1:0] wait_cnt;
    logic [4:0] rf_wa;
    logic [7:0] rf_wd;
    logic       rf_we;
    logic [4:0] rd_hi_addr;
    logic [7:0] a_val;
    logic [7:0] b_val;
    logic [7:0] c_val;
    logic [7:0] alu_b;
    logic       alu_cin;
    cab_alu_e   alu_fn;
    logic [7:0] alu_res;
    logic [5:0] alu_flags;
    logic [5:0] flag_mask;
    logic       store_res;
    logic       take;
    logic       skip;
    logic [1:0] cycles;
    logic [15:0] word_sum;
    logic [15:0] word_src;
    logic [15:0] ret_addr;
    logic [15:0] next_pc;
    logic [5:0] word_flags;
    logic       pend_hi;
    logic       pend_call;
    logic [7:0] pend_hi_val;
    logic [4:0] pend_hi_addr;
    logic [7:0] pend_hi_ret;

    assign take       = i_valid && o_ready && i_ce;
    assign rd_hi_addr = i_rd + 5'd1;

    cab_regfile u_rf (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_we       (rf_we),
        .i_wa       (rf_wa),
        .i_wd       (rf_wd),
        .i_ra       (i_rd),
        .i_rb       (i_op == CAB_OP_JMPZ || i_op == CAB_OP_CALLZ ? `CAB_Z_LO : i_rr),
        .i_rc       (i_op == CAB_OP_JMPZ || i_op == CAB_OP_CALLZ ? `CAB_Z_HI : rd_hi_addr),
        .o_ra       (a_val),
        .o_rb       (b_val),
        .o_rc       (c_val)
    );

    // operand and function select
    always_comb begin
        alu_b     = b_val;
        alu_cin   = 1'b0;
        alu_fn    = CAB_ALU_ADD;
        flag_mask = 6'h00;
        store_res = 1'b0;
        case (i_op)
            CAB_OP_ADD, CAB_OP_ADC: begin
                alu_cin   = (i_op == CAB_OP_ADC) && o_sreg[`CAB_FLG_C];
                flag_mask = 6'b10_1111;
                store_res = 1'b1;
            end
            CAB_OP_SUB, CAB_OP_SUBK: begin
                alu_fn    = CAB_ALU_SUB;
                alu_b     = (i_op == CAB_OP_SUBK) ? i_imm : b_val;
                flag_mask = 6'b10_1111;
                store_res = 1'b1;
            end
            CAB_OP_SUBB, CAB_OP_SUBBK: begin
                alu_fn    = CAB_ALU_SUB;
                alu_b     = (i_op == CAB_OP_SUBBK) ? i_imm : b_val;
                alu_cin   = o_sreg[`CAB_FLG_C];
                flag_mask = 6'b10_1111;
                store_res = 1'b1;
            end
            CAB_OP_AND, CAB_OP_ANDK: begin
                alu_fn    = CAB_ALU_AND;
                alu_b     = (i_op == CAB_OP_ANDK) ? i_imm : b_val;
                flag_mask = 6'b00_1110;
                store_res = 1'b1;
            end
            CAB_OP_OR, CAB_OP_ORK, CAB_OP_XOR: begin
                alu_fn    = (i_op == CAB_OP_XOR) ? CAB_ALU_XOR : CAB_ALU_OR;
                alu_b     = (i_op == CAB_OP_ORK) ? i_imm : b_val;
                flag_mask = 6'b00_1110;
                store_res = 1'b1;
            end
            CAB_OP_TEST: begin
                alu_fn    = CAB_ALU_AND;
                alu_b     = a_val;
                flag_mask = 6'b00_1110;
                store_res = 1'b1;
            end
            CAB_OP_SETM: begin
                alu_fn    = CAB_ALU_OR;
                alu_b     = i_imm;
                flag_mask = 6'b00_1110;
                store_res = 1'b1;
            end
            CAB_OP_CLRM: begin
                alu_fn    = CAB_ALU_AND;
                alu_b     = `CAB_MASK_ALL - i_imm;
                flag_mask = 6'b00_1110;
                store_res = 1'b1;
            end
            CAB_OP_CMP, CAB_OP_CMPB, CAB_OP_CMPK: begin
                alu_fn    = CAB_ALU_SUB;
                alu_b     = (i_op == CAB_OP_CMPK) ? i_imm : b_val;
                alu_cin   = (i_op == CAB_OP_CMPB) && o_sreg[`CAB_FLG_C];
                flag_mask = 6'b10_1111;
            end
            default: begin
                alu_b = b_val;
            end
        endcase
    end

    cab_alu u_alu (
        .i_a     (a_val),
        .i_b     (alu_b),
        .i_cin   (alu_cin),
        .i_fn    (alu_fn),
        .o_res   (alu_res),
        .o_flags (alu_flags)
    );

    // word arithmetic on the register pair, immediate is zero extended
    always_comb begin
        word_src = {c_val, a_val};
        word_flags = 6'h00;
        if (i_op == CAB_OP_WSUB) begin
            word_sum = word_src - {8'h00, i_imm};
            word_flags[`CAB_FLG_C] = word_sum[15] & ~word_src[15];
            word_flags[`CAB_FLG_V] = word_src[15] & ~word_sum[15];
        end else begin
            word_sum = word_src + {8'h00, i_imm};
            word_flags[`CAB_FLG_C] = ~word_sum[15] & word_src[15];
            word_flags[`CAB_FLG_V] = ~word_src[15] & word_sum[15];
        end
        word_flags[`CAB_FLG_Z] = (word_sum == 16'h0000);
        word_flags[`CAB_FLG_N] = word_sum[15];
        word_flags[`CAB_FLG_S] = word_sum[15] ^ word_flags[`CAB_FLG_V];
    end

    // skip decision, flags untouched by every skip form
    always_comb begin
        case (i_op)
            CAB_OP_CMPSK: skip = (a_val == b_val);
            CAB_OP_SKRC: skip = ~b_val[i_bit];
            CAB_OP_SKRS: skip = b_val[i_bit];
            CAB_OP_SKIC: skip = ~i_io_val[i_bit];
            CAB_OP_SKIS: skip = i_io_val[i_bit];
            default:     skip = 1'b0;
        endcase
    end

    // cycle count and next program counter
    always_comb begin
        ret_addr = o_pc + 16'h0001;
        next_pc  = ret_addr;
        cycles   = `CAB_CYC_ONE;
        case (i_op)
            CAB_OP_WADD, CAB_OP_WSUB: cycles = `CAB_CYC_WORD;
            CAB_OP_JMPZ: begin
                next_pc = {c_val, b_val};
                cycles  = `CAB_CYC_WORD;
            end
            CAB_OP_CALLZ: begin
                next_pc = {c_val, b_val};
                cycles  = `CAB_CYC_CALL;
            end
            CAB_OP_CMPSK, CAB_OP_SKRC, CAB_OP_SKRS, CAB_OP_SKIC, CAB_OP_SKIS: begin
                if (skip) begin
                    next_pc = o_pc + (i_next_two_word ? 16'h0003 : 16'h0002);
                    cycles  = i_next_two_word ? `CAB_CYC_CALL : `CAB_CYC_WORD;
                end
            end
            default: cycles = `CAB_CYC_ONE;
        endcase
    end

    // register write: low byte at issue, high byte of a pair one cycle later
    always_comb begin
        rf_we = 1'b0;
        rf_wa = i_rd;
        rf_wd = alu_res;
        if (pend_hi) begin
            rf_we = 1'b1;
            rf_wa = pend_hi_addr;
            rf_wd = pend_hi_val;
        end else if (take && (i_op == CAB_OP_WADD || i_op == CAB_OP_WSUB)) begin
            rf_we = 1'b1;
            rf_wd = word_sum[7:0];
        end else if (take && store_res) begin
            rf_we = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_hi      <= 1'b0;
            pend_hi_val  <= 8'h00;
            pend_hi_addr <= 5'h00;
        end else if (i_ce) begin
            pend_hi <= take && (i_op == CAB_OP_WADD || i_op == CAB_OP_WSUB);
            if (take) begin
                pend_hi_val  <= word_sum[15:8];
                pend_hi_addr <= rd_hi_addr;
            end
        end
    end

    // status flags: only the bits an operation owns are changed
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sreg <= 6'h00;
        end else if (i_ce && take) begin
            if (i_op == CAB_OP_WADD || i_op == CAB_OP_WSUB) begin
                o_sreg <= (o_sreg & ~6'b01_1111) | (word_flags & 6'b01_1111);
            end else begin
                o_sreg <= (o_sreg & ~flag_mask) | (alu_flags & flag_mask);
            end
        end
    end

    // sequencing: multi-cycle ops hold o_ready low for the extra cycles
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state    <= CAB_ST_IDLE;
            wait_cnt <= 2'd0;
            o_ready  <= 1'b1;
            o_done   <= 1'b0;
            o_pc     <= 16'h0000;
        end else if (i_ce) begin
            case (state)
                CAB_ST_IDLE: begin
                    o_done <= 1'b0;
                    if (take) begin
                        o_pc <= next_pc;
                        if (cycles == `CAB_CYC_ONE) begin
                            o_done <= 1'b1;
                        end else begin
                            state    <= CAB_ST_WAIT;
                            wait_cnt <= cycles - 2'd1;
                            o_ready  <= 1'b0;
                        end
                    end
                end
                CAB_ST_WAIT: begin
                    wait_cnt <= wait_cnt - 2'd1;
                    if (wait_cnt == 2'd1) begin
                        state   <= CAB_ST_IDLE;
                        o_ready <= 1'b1;
                        o_done  <= 1'b1;
                    end
                end
                default: state <= CAB_ST_IDLE;
            endcase
        end
    end

    // return address push, low byte then high byte, stack grows down
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sp        <= `CAB_SP_RESET;
            o_push_we   <= 1'b0;
            o_push_addr <= 16'h0000;
            o_push_data <= 8'h00;
            pend_call   <= 1'b0;
            pend_hi_ret <= 8'h00;
        end else if (i_ce) begin
            o_push_we <= 1'b0;
            pend_call <= 1'b0;
            if (take && i_op == CAB_OP_CALLZ) begin
                o_push_we   <= 1'b1;
                o_push_addr <= o_sp;
                o_push_data <= ret_addr[7:0];
                o_sp        <= o_sp - 16'h0001;
                pend_call   <= 1'b1;
                pend_hi_ret <= ret_addr[15:8];
            end else if (pend_call) begin
                o_push_we   <= 1'b1;
                o_push_addr <= o_sp;
                o_push_data <= pend_hi_ret;
                o_sp        <= o_sp - 16'h0001;
            end
        end
    end

endmodule // cab_exec
`default_nettype wire

// >>> tb/cab_exec_properties.sv
// assertions on execute block timing, pc steps and flag retention
`timescale 1ns/10ps
`default_nettype none
module cab_exec_properties
    import cab_pkg::*;
(
    // clocking
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    // issue
    input  wire logic             i_valid,
    input  wire cab_pkg::cab_op_e i_op,
    input  wire logic       [2:0] i_bit,
    input  wire logic       [7:0] i_io_val,
    input  wire logic             i_next_two_word,
    // status
    input  wire logic             o_ready,
    input  wire logic             o_done,
    input  wire logic      [15:0] o_pc,
    input  wire logic       [5:0] o_sreg,
    input  wire logic      [15:0] o_sp,
    input  wire logic             o_push_we
);
    logic tk;
    logic one_c;
    logic io_skip;
    assign tk = i_valid && o_ready && i_ce;
    assign one_c = tk && (i_op inside {[CAB_OP_ADD:CAB_OP_ADC], [CAB_OP_SUB:CAB_OP_SUBBK],
                                       [CAB_OP_AND:CAB_OP_CLRM], [CAB_OP_CMP:CAB_OP_CMPK]});
    // io skips are judged here, the tested bit is visible at the ports
    assign io_skip = tk && ((i_op == CAB_OP_SKIC && !i_io_val[i_bit])
                         || (i_op == CAB_OP_SKIS && i_io_val[i_bit]));

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    one_cycle_done_a: assert property (one_c |=> o_done && o_ready)
        else $error("single cycle op late");
    word_two_cycle_a: assert property (tk && i_op inside {CAB_OP_WADD, CAB_OP_WSUB}
        |=> !o_done && !o_ready ##1 o_done) else $error("word op not two cycles");
    jump_flags_kept_a: assert property (tk && i_op == CAB_OP_JMPZ
        |=> $stable(o_sreg) && !o_done ##1 o_done && $stable(o_sreg)) else $error("jump bad");
    call_three_a: assert property (tk && i_op == CAB_OP_CALLZ
        |=> !o_done [*2] ##1 o_done && o_sp == $past(o_sp, 3) - 16'h0002)
        else $error("call timing or stack bad");
    call_push_a: assert property (tk && i_op == CAB_OP_CALLZ |-> ##[1:3] o_push_we)
        else $error("call made no stack write");
    logic_carry_kept_a: assert property (tk && i_op inside {[CAB_OP_AND:CAB_OP_CLRM]}
        |=> o_sreg[0] == $past(o_sreg[0]) && o_sreg[5:4] == $past(o_sreg[5:4]))
        else $error("logic op touched carry");
    skip_flags_kept_a: assert property (tk && i_op inside {CAB_OP_CMPSK,
        [CAB_OP_SKRC:CAB_OP_SKIS]} |=> $stable(o_sreg)) else $error("skip changed flags");
    io_no_skip_a: assert property (tk && i_op inside {CAB_OP_SKIC, CAB_OP_SKIS} && !io_skip
        |=> o_done && o_pc == $past(o_pc) + 16'h0001) else $error("io skip taken wrongly");
    io_skip_one_a: assert property (io_skip && !i_next_two_word
        |=> !o_done ##1 o_done && o_pc == $past(o_pc, 2) + 16'h0002) else $error("skip one bad");
    io_skip_two_a: assert property (io_skip && i_next_two_word
        |=> !o_done ##1 !o_done ##1 o_done && o_pc == $past(o_pc, 3) + 16'h0003)
        else $error("skip two bad");
endmodule // cab_exec_properties
`default_nettype wire

// >>> tb/cab_exec_tb_top.sv
// self-checking bench for the execute block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %0t: got %0h expected %0h", $time, (g), (e)); end end
module cab_exec_tb_top;
    import cab_pkg::*;
    logic        i_core_clk;
    logic        i_rst_n;
    logic        i_valid;
    cab_op_e     i_op;
    logic  [4:0] i_rd;
    logic  [4:0] i_rr;
    logic  [7:0] i_imm;
    logic  [2:0] i_bit;
    logic  [7:0] i_io_val;
    logic        i_next_two_word;
    logic        o_ready;
    logic        o_done;
    logic [15:0] o_pc;
    logic  [5:0] o_sreg;
    logic [15:0] o_sp;
    logic        o_push_we;
    logic [15:0] o_push_addr;
    logic  [7:0] o_push_data;
    int          n_fail;
    int          checks_done;
    int          cyc;
    logic [15:0] epc;
    logic  [5:0] s0;
    logic [23:0] pushes[$];

    // clock enable tied high, freezing is not exercised here
    cab_exec cab_exec_i (.i_core_clk, .i_rst_n, .i_ce(1'b1), .i_valid, .i_op, .i_rd, .i_rr,
        .i_imm, .i_bit, .i_io_val, .i_next_two_word, .o_ready, .o_done, .o_pc, .o_sreg,
        .o_sp, .o_push_we, .o_push_addr, .o_push_data);

    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    task automatic conclude();
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [5:0] aflg(input logic [7:0] a, b, input logic c, sb);
        logic [8:0] r;
        logic [4:0] q;
        logic       v;
        r = sb ? {1'b0, a} - {1'b0, b} - c : {1'b0, a} + {1'b0, b} + c;
        q = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - c : {1'b0, a[3:0]} + {1'b0, b[3:0]} + c;
        v = sb ? (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7])
               : (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        return {q[4], 1'b0, v, r[7], r[7:0] == 8'h00, r[8]};
    endfunction

    // offer one op, wait for take and completion, leave one idle cycle
    task automatic issue(input cab_op_e op, input logic [4:0] rd, rr, input logic [7:0] k,
                         input logic [2:0] bt, input logic [7:0] io, input logic tw);
        int w;
        w = 0;
        i_op = op;
        i_rd = rd;
        i_rr = rr;
        i_imm = k;
        i_bit = bt;
        i_io_val = io;
        i_next_two_word = tw;
        i_valid = 1'b1;
        while (o_ready !== 1'b1 && w < 20) begin
            @(posedge i_core_clk);
            #1;
            w++;
        end
        @(posedge i_core_clk);
        #1;
        i_valid = 1'b0;
        cyc = 1;
        pushes.delete();
        while (o_done !== 1'b1 && cyc < 8) begin
            if (o_push_we === 1'b1) pushes.push_back({o_push_addr, o_push_data});
            @(posedge i_core_clk);
            #1;
            cyc++;
        end
        if (o_push_we === 1'b1) pushes.push_back({o_push_addr, o_push_data});
        if (o_done !== 1'b1 || w == 20) begin
            n_fail++;
            $display("Error %0t: op never completed", $time);
            conclude();
        end
        @(posedge i_core_clk);
        #1;
    endtask

    task automatic do_ar(input cab_op_e op, input logic [4:0] rd, rr, input logic [7:0] k, a, b,
                         input logic c, sb);
        issue(op, rd, rr, k, 3'h0, 8'h00, 1'b0);
        epc = epc + 16'h0001;
        `CHK(cyc, 1)
        `CHK(o_pc, epc)
        `CHK(o_sreg & 6'h2F, aflg(a, b, c, sb))
    endtask

    task automatic do_lg(input cab_op_e op, input logic [4:0] rd, rr, input logic [7:0] k, res,
                         input logic c);
        issue(op, rd, rr, k, 3'h0, 8'h00, 1'b0);
        epc = epc + 16'h0001;
        `CHK(cyc, 1)
        `CHK(o_pc, epc)
        `CHK(o_sreg & 6'h07, {3'h0, res[7], res == 8'h00, c})
    endtask

    task automatic sk(input cab_op_e op, input logic [4:0] rd, rr, input logic [2:0] bt,
                      input logic [7:0] io, input logic tw, input int n);
        s0 = o_sreg;
        issue(op, rd, rr, 8'h00, bt, io, tw);
        epc = epc + 16'(n);
        `CHK(cyc, n)
        `CHK(o_pc, epc)
        `CHK(o_sreg, s0)
    endtask

    task automatic wd(input cab_op_e op, input logic [7:0] k, input logic [4:0] f);
        issue(op, 5'd24, 5'd0, k, 3'h0, 8'h00, 1'b0);
        epc = epc + 16'h0001;
        `CHK(cyc, 2)
        `CHK(o_pc, epc)
        `CHK(o_sreg[4:0], f)
    endtask

    task automatic sc_arith();
        do_lg(CAB_OP_ORK, 16, 0, 8'h0F, 8'h0F, 0);
        do_lg(CAB_OP_ORK, 17, 0, 8'h01, 8'h01, 0);
        do_ar(CAB_OP_ADD, 16, 17, 8'h00, 8'h0F, 8'h01, 0, 0);
        do_ar(CAB_OP_SUBK, 18, 0, 8'h01, 8'h00, 8'h01, 0, 1);
        do_ar(CAB_OP_ADC, 16, 17, 8'h00, 8'h10, 8'h01, 1, 0);
        do_ar(CAB_OP_SUB, 16, 17, 8'h00, 8'h12, 8'h01, 0, 1);
        do_ar(CAB_OP_CMPK, 17, 0, 8'h02, 8'h01, 8'h02, 0, 1);
        do_ar(CAB_OP_SUBB, 16, 17, 8'h00, 8'h11, 8'h01, 1, 1);
        do_ar(CAB_OP_SUBBK, 16, 0, 8'h10, 8'h0F, 8'h10, 0, 1);
        do_ar(CAB_OP_SUBBK, 16, 0, 8'h01, 8'hFF, 8'h01, 1, 1);
        do_ar(CAB_OP_CMP, 17, 16, 8'h00, 8'h01, 8'hFD, 0, 1);
        do_ar(CAB_OP_CMPB, 16, 17, 8'h00, 8'hFD, 8'h01, 1, 1);
        do_ar(CAB_OP_CMPK, 16, 0, 8'hFD, 8'hFD, 8'hFD, 0, 1);
    endtask

    task automatic sc_logic();
        do_ar(CAB_OP_CMPK, 17, 0, 8'h02, 8'h01, 8'h02, 0, 1);
        do_lg(CAB_OP_AND, 16, 17, 8'h00, 8'h01, 1);
        do_lg(CAB_OP_ANDK, 16, 0, 8'h00, 8'h00, 1);
        do_lg(CAB_OP_ORK, 5, 0, 8'hA5, 8'hA5, 1);
        do_lg(CAB_OP_XOR, 17, 17, 8'h00, 8'h00, 1);
        do_lg(CAB_OP_OR, 17, 5, 8'h00, 8'hA5, 1);
        do_lg(CAB_OP_TEST, 5, 5, 8'h00, 8'hA5, 1);
        do_lg(CAB_OP_SETM, 16, 0, 8'h81, 8'h81, 1);
        do_lg(CAB_OP_CLRM, 16, 0, 8'h01, 8'h80, 1);
        do_lg(CAB_OP_CLRM, 16, 0, 8'h80, 8'h00, 1);
        do_ar(CAB_OP_CMPK, 5, 0, 8'hA5, 8'hA5, 8'hA5, 0, 1);
    endtask

    task automatic sc_word();
        do_lg(CAB_OP_ORK, 24, 0, 8'hFF, 8'hFF, 0);
        do_lg(CAB_OP_ORK, 25, 0, 8'hFF, 8'hFF, 0);
        wd(CAB_OP_WADD, 8'h01, 5'h03);
        wd(CAB_OP_WSUB, 8'h01, 5'h15);
        do_ar(CAB_OP_CMPK, 25, 0, 8'hFF, 8'hFF, 8'hFF, 0, 1);
    endtask

    task automatic sc_jump();
        do_lg(CAB_OP_ORK, 30, 0, 8'h34, 8'h34, 0);
        do_lg(CAB_OP_ORK, 31, 0, 8'h12, 8'h12, 0);
        s0 = o_sreg;
        issue(CAB_OP_JMPZ, 0, 0, 8'h00, 3'h0, 8'h00, 1'b0);
        `CHK(cyc, 2)
        `CHK(o_pc, 16'h1234)
        `CHK(o_sreg, s0)
        issue(CAB_OP_CALLZ, 0, 0, 8'h00, 3'h0, 8'h00, 1'b0);
        epc = 16'h1234;
        `CHK(cyc, 3)
        `CHK(o_pc, epc)
        `CHK(o_sp, 16'h00FD)
        `CHK(pushes.size(), 2)
        `CHK(pushes[0], {16'h00FF, 8'h35})
        `CHK(pushes[1], {16'h00FE, 8'h12})
        `CHK(o_sreg, s0)
    endtask

    task automatic sc_skip();
        sk(CAB_OP_SKRC, 0, 5, 3'h1, 8'h00, 0, 2);
        sk(CAB_OP_SKRC, 0, 5, 3'h0, 8'h00, 1, 1);
        sk(CAB_OP_SKRS, 0, 5, 3'h7, 8'h00, 1, 3);
        sk(CAB_OP_SKRS, 0, 5, 3'h6, 8'h00, 0, 1);
        sk(CAB_OP_SKIC, 0, 0, 3'h2, 8'h04, 0, 1);
        sk(CAB_OP_SKIC, 0, 0, 3'h3, 8'h04, 1, 3);
        sk(CAB_OP_SKIS, 0, 0, 3'h2, 8'h04, 0, 2);
        sk(CAB_OP_SKIS, 0, 0, 3'h0, 8'h04, 1, 1);
        sk(CAB_OP_CMPSK, 5, 17, 3'h0, 8'h00, 0, 2);
        sk(CAB_OP_CMPSK, 5, 16, 3'h0, 8'h00, 1, 1);
        sk(CAB_OP_CMPSK, 5, 17, 3'h0, 8'h00, 1, 3);
    endtask

    // second op reads the register the first wrote one edge earlier
    task automatic sc_b2b();
        i_op = CAB_OP_ORK;
        i_rd = 5'd20;
        i_imm = 8'h01;
        i_valid = 1'b1;
        @(posedge i_core_clk);
        #1;
        `CHK(o_done, 1'b1)
        i_op = CAB_OP_CMPK;
        @(posedge i_core_clk);
        #1;
        i_valid = 1'b0;
        epc = epc + 16'h0002;
        `CHK(o_done, 1'b1)
        `CHK(o_sreg[1:0], 2'h2)
        `CHK(o_pc, epc)
        @(posedge i_core_clk);
        #1;
    endtask

    initial begin
        n_fail = 0;
        checks_done = 0;
        epc = 16'h0000;
        i_rst_n = 1'b0;
        i_valid = 1'b0;
        i_op = CAB_OP_NOP;
        i_rd = 5'h00;
        i_rr = 5'h00;
        i_imm = 8'h00;
        i_bit = 3'h0;
        i_io_val = 8'h00;
        i_next_two_word = 1'b0;
        repeat (8) @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b1;
        @(posedge i_core_clk);
        #1;
        sc_arith();
        sc_logic();
        sc_word();
        sc_jump();
        sc_skip();
        sc_b2b();
        conclude();
    end
endmodule // cab_exec_tb_top

bind cab_exec cab_exec_properties cab_exec_properties_i (.i_core_clk, .i_rst_n, .i_ce,
    .i_valid, .i_op, .i_bit, .i_io_val, .i_next_two_word, .o_ready, .o_done, .o_pc, .o_sreg,
    .o_sp, .o_push_we);
`default_nettype wire
